// ==== include/swt_defines.vh ====
/*
 * sleep/wake timer constants: offsets, fields, resets, clocks.
 * assumes an 8-bit register port with byte addresses.
 */
`ifndef SWT_DEFINES_VH
`define SWT_DEFINES_VH

// register offsets (byte addresses on the register port)
`define SWT_ADDR_IRQ_CTRL    8'hA1
`define SWT_ADDR_CTRL        8'hA2
`define SWT_ADDR_EVT_LOW     8'hA3
`define SWT_ADDR_EVT_HIGH    8'hA4
`define SWT_ADDR_CNT_LOW     8'hA5
`define SWT_ADDR_CNT_HIGH    8'hA6
`define SWT_ADDR_CONFIG      8'hA8
`define SWT_ADDR_INT_STATUS  8'hA9
`define SWT_ADDR_INT_MASK    8'hAA

// sleep_timer_control fields
`define SWT_CTRL_RES_LSB     0
`define SWT_CTRL_CLEAR_BIT   2
`define SWT_CTRL_RSV_LSB     4
`define SWT_CTRL_RSV_RESET   3'h7

// sleep_irq_control fields
`define SWT_IRQ_PEND_BIT     0
`define SWT_IRQ_MASK_BIT     4
`define SWT_IRQ_RSV_BIT      5

// own configuration register fields
`define SWT_CFG_MODE_LSB     0
`define SWT_CFG_ENABLE_BIT   2
`define SWT_CFG_RCSEL_BIT    3

// interrupt status / mask bits
`define SWT_INT_CPU_FLAG     0
`define SWT_INT_WAKE         1

// reset values and counter clear value
`define SWT_EVT_LOW_RESET    8'h6B
`define SWT_EVT_HIGH_RESET   8'h87
`define SWT_CNT_CLEAR_VALUE  31'h0000_0004

// power modes
`define SWT_MODE_ACTIVE      2'h0
`define SWT_MODE_DEEP        2'h3

// clock figures
`define SWT_CLK_HZ           100000000
`define SWT_XTAL_HZ          32768
`define SWT_REF_HZ           26000000
`define SWT_RC_DIV           750
`define SWT_ACC_W            40

`endif

// ==== hdl/swt_tick_gen.v ====
/*
 * sleep tick generator: one-cycle enables at the crystal rate or
 * at reference / 750, from a fractional accumulator.
 * assumes one system clock and a synchronous active-low reset.
 */
`timescale 1ns/10ps
`include "swt_defines.vh"

module swt_tick_gen #(
    parameter CLK_HZ = `SWT_CLK_HZ,   // system clock rate
    parameter REF_HZ = `SWT_REF_HZ    // synthesizer reference rate
) (
    input  wire clk,                  // system clock
    input  wire rst_n,                // synchronous reset, active low
    input  wire rc_sel,               // 1: rc source, 0: crystal
    output reg  tick                  // one-cycle sleep clock enable
);

    //////////////////////////////////////////////////////////////////
    // accumulator constants, sized so the rc modulus does not wrap
    localparam [`SWT_ACC_W-1:0] CLK_W   = CLK_HZ;
    localparam [`SWT_ACC_W-1:0] XTAL_W  = `SWT_XTAL_HZ;
    localparam [`SWT_ACC_W-1:0] REF_W   = REF_HZ;
    localparam [`SWT_ACC_W-1:0] RCDIV_W = `SWT_RC_DIV;
    localparam [`SWT_ACC_W-1:0] MOD_RC  = CLK_W * RCDIV_W;

    reg  [`SWT_ACC_W-1:0] acc;        // phase accumulator
    reg                   rc_q;       // source seen last cycle
    wire [`SWT_ACC_W-1:0] inc;        // phase step per clock
    wire [`SWT_ACC_W-1:0] modulus;    // phase per sleep tick
    wire [`SWT_ACC_W-1:0] sum;        // advanced phase

    assign inc     = rc_sel ? REF_W : XTAL_W;
    assign modulus = rc_sel ? MOD_RC : CLK_W;
    assign sum     = acc + inc;

    //////////////////////////////////////////////////////////////////
    // advance phase; restart it when the source changes so the
    // remainder of one source never leaks into the other
    always @(posedge clk) begin
        if (!rst_n) begin
            acc  <= {`SWT_ACC_W{1'b0}};
            rc_q <= 1'b0;
            tick <= 1'b0;
        end else begin
            rc_q <= rc_sel;
            if (rc_q != rc_sel) begin
                // source switched: restart phase
                acc  <= {`SWT_ACC_W{1'b0}};
                tick <= 1'b0;
            end else if (sum >= modulus) begin
                // one sleep period elapsed
                acc  <= sum - modulus;
                tick <= 1'b1;
            end else begin
                acc  <= sum;
                tick <= 1'b0;
            end
        end
    end

endmodule // swt_tick_gen

// ==== hdl/swt_sleep_timer.v ====
/*
 * sleep/wake timer: sleep counter, window,
 * event compare, pending and cpu flags,
 * interrupt and wake requests, register port.
 * assumes one clock, synchronous active-low reset,
 * never both strobes at once.
 */
// Local design decision: strobed register access.
`timescale 1ns/10ps
`include "swt_defines.vh"

module swt_sleep_timer #(
    parameter CLK_HZ = `SWT_CLK_HZ,     // system clock rate
    parameter REF_HZ = `SWT_REF_HZ      // synthesizer reference rate
) (
    input  wire       clk,              // system clock
    input  wire       rst_n,            // synchronous reset, active low
    input  wire [7:0] reg_addr,         // register byte address
    input  wire [7:0] reg_wdata,        // register write data
    input  wire       reg_wr,           // write strobe
    input  wire       reg_rd,           // read strobe
    output reg  [7:0] reg_rdata,        // read data, cycle after strobe
    output reg        wake_req,         // pulse: return to active mode
    output wire       cpu_sleep_irq_flag,   // cpu-level flag, level
    output wire       sleep_tick_interrupt, // request to processor
    output wire       irq               // combined interrupt, level
);

    //////////////////////////////////////////////////////////////////
    // address match, used by every register write
    function hit;
        input [7:0] addr;               // presented address
        input [7:0] offset;             // register offset
        begin
            hit = (addr == offset);
        end
    endfunction

    // 16-bit window of the sleep counter for a resolution setting
    function [15:0] window;
        input [30:0] count;             // sleep counter
        input [1:0]  res;               // resolution setting
        begin
            case (res)
                2'h0:    window = count[15:0];
                2'h1:    window = count[20:5];
                2'h2:    window = count[25:10];
                2'h3:    window = count[30:15];
                default: window = count[15:0];
            endcase
        end
    endfunction

    // true when the bits below the window are all zero
    function below_zero;
        input [30:0] count;             // sleep counter
        input [1:0]  res;               // resolution setting
        begin
            case (res)
                2'h0:    below_zero = 1'b1;
                2'h1:    below_zero = (count[4:0] == 5'h00);
                2'h2:    below_zero = (count[9:0] == 10'h000);
                2'h3:    below_zero = (count[14:0] == 15'h0000);
                default: below_zero = 1'b1;
            endcase
        end
    endfunction

    //////////////////////////////////////////////////////////////////
    // state
    reg  [30:0] count;                  // 31-bit sleep counter
    reg  [15:0] mantissa;               // wake_event_mantissa
    reg  [1:0]  res;                    // resolution field
    reg  [2:0]  ctrl_rsv;               // reserved control bits 6:4
    reg         event_zero_pending;     // local pending flag
    reg         event_zero_irq_mask;    // passes event to cpu flag
    reg         irq_rsv;                // reserved irq control bit 5
    reg  [1:0]  power_mode;             // power-mode selection
    reg         sleep_irq_enable;       // cpu interrupt enable
    reg         rc_sel;                 // 1: rc oscillator source
    reg  [1:0]  int_status;             // sticky event bits
    reg  [1:0]  int_mask;               // gates status onto irq

    wire        tick;                   // sleep clock enable
    wire [30:0] count_inc;              // counter plus one
    wire [15:0] next_window;            // window after this tick
    wire [15:0] cur_window;             // window of the current count
    wire        wake_event;             // event zero this cycle
    wire        counter_clear;          // clear bit written as one
    wire        wr_irq_ctrl;            // write to sleep_irq_control
    wire        wr_ctrl;                // write to control
    wire        wr_status;              // write to status
    wire        light_sleep;            // in a lighter sleep state
    wire [1:0]  status_set;             // hardware sets this cycle
    wire [1:0]  status_clr;             // software clears this cycle
    reg  [7:0]  next_rdata;             // read data for next cycle

    //////////////////////////////////////////////////////////////////
    // slow sleep clock as a one-cycle enable
    swt_tick_gen #(
        .CLK_HZ (CLK_HZ),
        .REF_HZ (REF_HZ)
    ) u_tick (
        .clk    (clk),
        .rst_n  (rst_n),
        .rc_sel (rc_sel),
        .tick   (tick)
    );

    //////////////////////////////////////////////////////////////////
    // event compare: the window of the value about to be loaded
    // matches the mantissa at the start of a window step, so the
    // event fires once per interval of mantissa * 2^(5*res) ticks
    assign count_inc   = count + 31'h0000_0001;
    assign next_window = window(count_inc, res);
    assign cur_window  = window(count, res);
    assign wake_event  = tick && (next_window == mantissa)
                         && below_zero(count_inc, res);

    // write decodes
    assign wr_irq_ctrl   = reg_wr && hit(reg_addr, `SWT_ADDR_IRQ_CTRL);
    assign wr_ctrl       = reg_wr && hit(reg_addr, `SWT_ADDR_CTRL);
    assign wr_status     = reg_wr && hit(reg_addr, `SWT_ADDR_INT_STATUS);
    assign counter_clear = wr_ctrl && reg_wdata[`SWT_CTRL_CLEAR_BIT];

    // lighter sleep states are every mode but the deepest
    assign light_sleep = (power_mode != `SWT_MODE_DEEP);

    //////////////////////////////////////////////////////////////////
    // sleep counter: clear wins, then restart on event, then count;
    // resolution writes never touch it
    always @(posedge clk) begin
        if (!rst_n) begin
            count <= 31'h0000_0000;
        end else if (counter_clear) begin
            count <= `SWT_CNT_CLEAR_VALUE;
        end else if (wake_event) begin
            // interval restarts from zero
            count <= 31'h0000_0000;
        end else if (tick) begin
            count <= count_inc;
        end
    end

    //////////////////////////////////////////////////////////////////
    // control register: resolution, reserved bits; clear is a strobe
    always @(posedge clk) begin
        if (!rst_n) begin
            res      <= 2'h0;
            ctrl_rsv <= `SWT_CTRL_RSV_RESET;
        end else if (wr_ctrl) begin
            // only the view changes, the counter keeps running
            res      <= reg_wdata[`SWT_CTRL_RES_LSB +: 2];
            ctrl_rsv <= reg_wdata[`SWT_CTRL_RSV_LSB +: 3];
        end
    end

    //////////////////////////////////////////////////////////////////
    // mantissa bytes; software restarts the counter before lowering
    // the mantissa, otherwise the match waits until the 16-bit window wraps
    always @(posedge clk) begin
        if (!rst_n) begin
            mantissa[15:8] <= `SWT_EVT_HIGH_RESET;
            mantissa[7:0]  <= `SWT_EVT_LOW_RESET;
        end else if (reg_wr) begin
            if (hit(reg_addr, `SWT_ADDR_EVT_HIGH)) begin
                mantissa[15:8] <= reg_wdata;
            end
            if (hit(reg_addr, `SWT_ADDR_EVT_LOW)) begin
                mantissa[7:0] <= reg_wdata;
            end
        end
    end

    //////////////////////////////////////////////////////////////////
    // sleep_irq_control: pending flag set by event, cleared by
    // writing zero; a set in the same cycle wins
    always @(posedge clk) begin
        if (!rst_n) begin
            event_zero_pending  <= 1'b0;
            event_zero_irq_mask <= 1'b0;
            irq_rsv             <= 1'b0;
        end else begin
            if (wake_event) begin
                event_zero_pending <= 1'b1;
            end else if (wr_irq_ctrl &&
                         !reg_wdata[`SWT_IRQ_PEND_BIT]) begin
                event_zero_pending <= 1'b0;
            end
            if (wr_irq_ctrl) begin
                event_zero_irq_mask <= reg_wdata[`SWT_IRQ_MASK_BIT];
                irq_rsv             <= reg_wdata[`SWT_IRQ_RSV_BIT];
            end
        end
    end

    //////////////////////////////////////////////////////////////////
    // own configuration: power mode, cpu enable, clock source
    always @(posedge clk) begin
        if (!rst_n) begin
            power_mode       <= `SWT_MODE_ACTIVE;
            sleep_irq_enable <= 1'b0;
            rc_sel           <= 1'b0;
        end else if (reg_wr && hit(reg_addr, `SWT_ADDR_CONFIG)) begin
            power_mode       <= reg_wdata[`SWT_CFG_MODE_LSB +: 2];
            sleep_irq_enable <= reg_wdata[`SWT_CFG_ENABLE_BIT];
            rc_sel           <= reg_wdata[`SWT_CFG_RCSEL_BIT];
        end
    end

    //////////////////////////////////////////////////////////////////
    // sticky status: cpu flag when the masked event fires, wake bit
    // when the event pulls the chip out of a lighter sleep state
    assign status_set[`SWT_INT_CPU_FLAG] =
        wake_event && event_zero_irq_mask;
    assign status_set[`SWT_INT_WAKE] = wake_event && light_sleep;
    assign status_clr = wr_status ? reg_wdata[1:0] : 2'h0;

    // write one to clear; a set in the same cycle wins
    always @(posedge clk) begin
        if (!rst_n) begin
            int_status <= 2'h0;
        end else begin
            int_status <= (int_status & ~status_clr) | status_set;
        end
    end

    // mask register, same layout as status
    always @(posedge clk) begin
        if (!rst_n) begin
            int_mask <= 2'h0;
        end else if (reg_wr && hit(reg_addr, `SWT_ADDR_INT_MASK)) begin
            int_mask <= reg_wdata[1:0];
        end
    end

    //////////////////////////////////////////////////////////////////
    // wake request pulse, one cycle after the event
    always @(posedge clk) begin
        if (!rst_n) begin
            wake_req <= 1'b0;
        end else begin
            wake_req <= wake_event && light_sleep;
        end
    end

    //////////////////////////////////////////////////////////////////
    // interrupt outputs
    assign cpu_sleep_irq_flag = int_status[`SWT_INT_CPU_FLAG];
    // request needs flag and enable, and only in power mode 00
    assign sleep_tick_interrupt = cpu_sleep_irq_flag
                                  && sleep_irq_enable
                                  && (power_mode == `SWT_MODE_ACTIVE);
    // combined output: gated cpu request or unmasked wake bit
    assign irq = (sleep_tick_interrupt && int_mask[`SWT_INT_CPU_FLAG])
                 || (int_status[`SWT_INT_WAKE] && int_mask[`SWT_INT_WAKE]);

    //////////////////////////////////////////////////////////////////
    // read multiplexer; unmapped addresses read zero
    always @* begin
        next_rdata = 8'h00;
        case (reg_addr)
            `SWT_ADDR_IRQ_CTRL: begin
                next_rdata = {2'h0, irq_rsv, event_zero_irq_mask,
                              3'h0, event_zero_pending};
            end
            `SWT_ADDR_CTRL: begin
                // clear bit always reads zero
                next_rdata = {1'b0, ctrl_rsv, 2'h0, res};
            end
            `SWT_ADDR_EVT_LOW: begin
                next_rdata = mantissa[7:0];
            end
            `SWT_ADDR_EVT_HIGH: begin
                next_rdata = mantissa[15:8];
            end
            `SWT_ADDR_CNT_LOW: begin
                next_rdata = cur_window[7:0];
            end
            `SWT_ADDR_CNT_HIGH: begin
                next_rdata = cur_window[15:8];
            end
            `SWT_ADDR_CONFIG: begin
                next_rdata = {4'h0, rc_sel, sleep_irq_enable,
                              power_mode};
            end
            `SWT_ADDR_INT_STATUS: begin
                next_rdata = {6'h00, int_status};
            end
            `SWT_ADDR_INT_MASK: begin
                next_rdata = {6'h00, int_mask};
            end
            default: begin
                next_rdata = 8'h00;
            end
        endcase
    end

    // read data stands only in the cycle after the strobe
    always @(posedge clk) begin
        if (!rst_n) begin
            reg_rdata <= 8'h00;
        end else if (reg_rd) begin
            reg_rdata <= next_rdata;
        end else begin
            reg_rdata <= 8'h00;
        end
    end

endmodule // swt_sleep_timer

// ==== verification/swt_sleep_timer_monitor.sv ====
/* checker of the sleep/wake timer ports.
   assumes binding to swt_sleep_timer, one clock, sync reset. */
`timescale 1ns/10ps
`include "swt_defines.vh"

module swt_sleep_timer_monitor (
    input wire       clk,                  // system clock
    input wire       rst_n,                // sync reset, active low
    input wire [7:0] reg_addr,             // register address
    input wire [7:0] reg_wdata,            // write data
    input wire       reg_wr,               // write strobe
    input wire       reg_rd,               // read strobe
    input wire [7:0] reg_rdata,            // read data
    input wire       wake_req,             // wake pulse
    input wire       cpu_sleep_irq_flag,   // cpu-level flag
    input wire       sleep_tick_interrupt, // processor request
    input wire       irq                   // combined interrupt
);
    reg [7:0] evt_lo; // shadow of mantissa low byte
    reg [7:0] evt_hi; // shadow of mantissa high byte
    reg [7:0] cfg;    // shadow of configuration register
    reg       msk;    // shadow of event mask bit

    ////////////////////////////////////////////////////////////////////
    // shadows follow the register writes
    always @(posedge clk) begin
        if (!rst_n) begin
            evt_lo <= `SWT_EVT_LOW_RESET;
            evt_hi <= `SWT_EVT_HIGH_RESET;
            cfg    <= 8'h00;
            msk    <= 1'b0;
        end else if (reg_wr) begin
            case (reg_addr)
                `SWT_ADDR_EVT_LOW:  evt_lo <= reg_wdata;
                `SWT_ADDR_EVT_HIGH: evt_hi <= reg_wdata;
                `SWT_ADDR_CONFIG:   cfg <= reg_wdata;
                `SWT_ADDR_IRQ_CTRL: msk <= reg_wdata[`SWT_IRQ_MASK_BIT];
                default: ;
            endcase
        end
    end

    ////////////////////////////////////////////////////////////////////
    default clocking cb @(posedge clk); endclocking
    default disable iff (!rst_n);

    rdata_idle_a: assert property (!$past(reg_rd) |-> reg_rdata == 8'h00)
        else $error("read data not idle");
    evt_low_read_a: assert property (
        $past(reg_rd) && $past(reg_addr) == `SWT_ADDR_EVT_LOW
        |-> reg_rdata == $past(evt_lo)) else $error("mantissa low wrong");
    evt_high_read_a: assert property (
        $past(reg_rd) && $past(reg_addr) == `SWT_ADDR_EVT_HIGH
        |-> reg_rdata == $past(evt_hi)) else $error("mantissa high wrong");
    clear_reads_zero_a: assert property (
        $past(reg_rd) && $past(reg_addr) == `SWT_ADDR_CTRL
        |-> !reg_rdata[2]) else $error("clear bit read as one");
    unmapped_read_a: assert property (
        $past(reg_rd) && $past(reg_addr) == 8'hA7 |-> reg_rdata == 8'h00)
        else $error("unmapped read not zero");
    req_gate_a: assert property (sleep_tick_interrupt |->
        cpu_sleep_irq_flag && cfg[2] && cfg[1:0] == 2'h0)
        else $error("request without its causes");
    req_cause_a: assert property (
        cpu_sleep_irq_flag && cfg[2] && cfg[1:0] == 2'h0
        |-> sleep_tick_interrupt) else $error("request missing");
    flag_event_a: assert property (wake_req && msk
        |-> cpu_sleep_irq_flag) else $error("cpu flag not set");
    flag_clear_a: assert property ($fell(cpu_sleep_irq_flag) |->
        $past(reg_wr) && $past(reg_addr) == `SWT_ADDR_INT_STATUS
        && $past(reg_wdata[0])) else $error("cpu flag fell alone");
    wake_pulse_a: assert property (wake_req |=> !wake_req)
        else $error("wake pulse too long");
    deep_no_wake_a: assert property (
        (cfg[1:0] == 2'h3) [*2] |-> !wake_req) else $error("deep wake");

    wake_c: cover property (wake_req);
    req_c: cover property (sleep_tick_interrupt);
    irq_c: cover property (irq);
endmodule // swt_sleep_timer_monitor

bind swt_sleep_timer swt_sleep_timer_monitor swt_sleep_timer_monitor_inst (
    .clk(clk), .rst_n(rst_n), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
    .wake_req(wake_req), .cpu_sleep_irq_flag(cpu_sleep_irq_flag),
    .sleep_tick_interrupt(sleep_tick_interrupt), .irq(irq));

// ==== verification/swt_cpu_model.sv ====
/* cpu model: register port master, request counter.
   assumes read data one cycle after the strobe. */
`timescale 1ns/10ps
`include "swt_defines.vh"

module swt_cpu_model (
    input  wire       clk,                  // system clock
    output reg  [7:0] reg_addr,             // register address
    output reg  [7:0] reg_wdata,            // write data
    output reg        reg_wr,               // write strobe
    output reg        reg_rd,               // read strobe
    input  wire [7:0] reg_rdata,            // read data
    input  wire       sleep_tick_interrupt, // request from timer
    output reg  [7:0] n_req                 // requests taken
);
    reg prev_req; // request level one cycle ago

    initial begin
        {reg_addr, reg_wdata, reg_wr, reg_rd, n_req, prev_req} = 0;
    end

    // count rising request edges as taken interrupts
    always @(posedge clk) begin
        prev_req <= sleep_tick_interrupt;
        if (sleep_tick_interrupt && !prev_req)
            n_req <= n_req + 8'h01;
    end

    // one-cycle write; idle lines show inverted values
    task wr(input [7:0] a, input [7:0] d);
        begin
            @(posedge clk);
            {reg_wr, reg_addr, reg_wdata} <= {1'b1, a, d};
            @(posedge clk);
            {reg_wr, reg_addr, reg_wdata} <= {1'b0, ~a, ~d};
            #1;
        end
    endtask

    // one-cycle read; data taken in the following cycle
    task rd(input [7:0] a, output [7:0] d);
        begin
            @(posedge clk);
            {reg_rd, reg_addr} <= {1'b1, a};
            @(posedge clk);
            {reg_rd, reg_addr} <= {1'b0, ~a};
            #1 d = reg_rdata;
        end
    endtask

    // restart the counter before loading a new mantissa
    task set_timer(input [7:0] ctrl, input [15:0] mant);
        begin
            wr(`SWT_ADDR_CTRL, ctrl | 8'h04);
            wr(`SWT_ADDR_EVT_HIGH, mant[15:8]);
            wr(`SWT_ADDR_EVT_LOW, mant[7:0]);
        end
    endtask
endmodule // swt_cpu_model

// ==== verification/tb_swt_sleep_timer.sv ====
/* bench of the sleep/wake timer: registers, window, events.
   assumes ticks every 2 (crystal) and 4 (rc) clocks. */
`timescale 1ns/10ps
`include "swt_defines.vh"

module tb_swt_sleep_timer;
    reg        clk;                        // system clock
    reg        rst_n;                      // sync reset
    wire [7:0] reg_addr, reg_wdata;        // master address and data
    wire [7:0] reg_rdata, n_req;           // read data, request count
    wire       reg_wr, reg_rd, wake_req;   // strobes, wake pulse
    wire       flag, sti, irq;             // flag, request, interrupt
    integer    n_errors, compares, n;      // counters, cycle count
    reg  [7:0] v0, v1;                     // read values
    reg        got;                        // pulse seen

    swt_sleep_timer #(.CLK_HZ(65536), .REF_HZ(12288000))
    swt_sleep_timer_inst (.clk(clk), .rst_n(rst_n), .reg_addr(reg_addr),
        .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
        .reg_rdata(reg_rdata), .wake_req(wake_req),
        .cpu_sleep_irq_flag(flag), .sleep_tick_interrupt(sti), .irq(irq));

    swt_cpu_model swt_cpu_model_inst (.clk(clk), .reg_addr(reg_addr),
        .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
        .reg_rdata(reg_rdata), .sleep_tick_interrupt(sti), .n_req(n_req));

    initial begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end

    ////////////////////////////////////////////////////////////////////
    task close_out;
        begin
            $display("errors %0d compares %0d", n_errors, compares);
            if (n_errors == 0 && compares > 0)
                $display("ALL CHECKS OK");
            else
                $display("CHECKS NOT OK");
            $finish;
        end
    endtask

    task chk(input string nm, input [7:0] exp, input [7:0] seen);
        begin
            compares = compares + 1;
            if (seen !== exp) begin
                n_errors = n_errors + 1;
                $display("CHECK FAILED %s exp %h got %h", nm, exp, seen);
            end
        end
    endtask

    task rchk(input [7:0] a, input [7:0] exp, input string nm);
        begin
            swt_cpu_model_inst.rd(a, v1);
            chk(nm, exp, v1);
        end
    endtask

    // short form of a cpu model write
    task w(input [7:0] a, input [7:0] d);
        swt_cpu_model_inst.wr(a, d);
    endtask

    // wait for a wake pulse within lim clocks, n counts the clocks;
    // a pulse that must come and does not ends the run
    task wait_wake(input integer lim, input must);
        begin
            n = 0;
            got = 1'b0;
            while (!got && n < lim) begin
                @(posedge clk);
                #1 got = wake_req;
                n = n + 1;
            end
            if (must && !got) begin
                n_errors = n_errors + 1;
                close_out;
            end
        end
    endtask

    // clocks between two wake pulses
    task gap(input [7:0] exp, input string nm);
        begin
            wait_wake(400, 1'b1);
            wait_wake(400, 1'b1);
            chk(nm, exp, n[7:0]);
        end
    endtask

    ////////////////////////////////////////////////////////////////////
    task t_regs;
        begin
            rchk(`SWT_ADDR_EVT_LOW, 8'h6B, "mant low reset");
            rchk(`SWT_ADDR_EVT_HIGH, 8'h87, "mant high reset");
            rchk(`SWT_ADDR_CTRL, 8'h70, "ctrl reset");
            rchk(8'hA7, 8'h00, "unmapped");
            w(`SWT_ADDR_EVT_LOW, 8'h5A);
            w(`SWT_ADDR_EVT_HIGH, 8'hC3);
            rchk(`SWT_ADDR_EVT_LOW, 8'h5A, "mant low");
            rchk(`SWT_ADDR_EVT_HIGH, 8'hC3, "mant high");
        end
    endtask

    task t_window;
        begin
            swt_cpu_model_inst.set_timer(8'h00, 16'hFFFF);
            swt_cpu_model_inst.rd(`SWT_ADDR_CNT_LOW, v0);
            chk("after clear", 8'h01, v0 >= 8'h04 && v0 <= 8'h07);
            repeat (200) @(posedge clk);
            swt_cpu_model_inst.rd(`SWT_ADDR_CNT_LOW, v0);
            w(`SWT_ADDR_CTRL, 8'h01);
            swt_cpu_model_inst.rd(`SWT_ADDR_CNT_LOW, v1);
            chk("res1 low", 8'h01, v1 == v0 >> 5 || v1 == (v0 + 8'h04) >> 5);
            rchk(`SWT_ADDR_CNT_HIGH, 8'h00, "res1 high");
            w(`SWT_ADDR_CTRL, 8'h02);
            rchk(`SWT_ADDR_CNT_LOW, 8'h00, "res2 low");
            w(`SWT_ADDR_CTRL, 8'h03);
            rchk(`SWT_ADDR_CNT_LOW, 8'h00, "res3 low");
            w(`SWT_ADDR_CTRL, 8'h00);
            swt_cpu_model_inst.rd(`SWT_ADDR_CNT_LOW, v1);
            chk("no restart", 8'h01, v1 > v0 && v1 - v0 < 8'h20);
        end
    endtask

    task t_event;
        begin
            w(`SWT_ADDR_CONFIG, 8'h04);
            w(`SWT_ADDR_INT_MASK, 8'h01);
            w(`SWT_ADDR_IRQ_CTRL, 8'h10);
            swt_cpu_model_inst.set_timer(8'h00, 16'h0028);
            gap(8'd80, "crystal gap");
            rchk(`SWT_ADDR_IRQ_CTRL, 8'h11, "pending");
            chk("cpu flag", 8'h01, flag);
            chk("request", 8'h01, sti);
            chk("irq", 8'h01, irq);
            rchk(`SWT_ADDR_INT_STATUS, 8'h03, "status");
            w(`SWT_ADDR_CONFIG, 8'h05);
            chk("blocked", 8'h00, sti);
            w(`SWT_ADDR_CONFIG, 8'h04);
            w(`SWT_ADDR_INT_MASK, 8'h00);
            chk("irq masked", 8'h00, irq);
            w(`SWT_ADDR_INT_STATUS, 8'h01);
            chk("flag cleared", 8'h00, flag);
            w(`SWT_ADDR_IRQ_CTRL, 8'h00);
            wait_wake(400, 1'b1);
            rchk(`SWT_ADDR_IRQ_CTRL, 8'h01, "pending unmasked");
            chk("flag masked", 8'h00, flag);
            chk("taken", 8'h01, n_req != 8'h00);
            swt_cpu_model_inst.set_timer(8'h01, 16'h0001);
            gap(8'd64, "res1 gap");
            w(`SWT_ADDR_CONFIG, 8'h0C);
            swt_cpu_model_inst.set_timer(8'h00, 16'h0028);
            gap(8'd160, "rc gap");
            w(`SWT_ADDR_CONFIG, 8'h07);
            wait_wake(400, 1'b0);
            chk("deep no wake", 8'h00, got);
        end
    endtask

    ////////////////////////////////////////////////////////////////////
    initial begin
        n_errors = 0;
        compares = 0;
        rst_n = 1'b0;
        repeat (10) @(posedge clk);
        rst_n <= 1'b1;
        t_regs;
        t_window;
        t_event;
        close_out;
    end
endmodule // tb_swt_sleep_timer
